// file: srpd_dev.sv
// Purpose: Flash end that decodes suspend, resume, deep sleep and status commands.
// Assumes: The host keeps its spacing rules, notably the resume to pause gap.
// Notes:   Erase and program are modelled as countdowns of configurable length.
// What this block does
// - Opcode 75h pauses an erase in progress.
// - Opcode 7Ah continues a paused erase.
// - Opcode 85h pauses a program in progress.
// - Opcode 8Ah continues a paused program.
// - Deep sleep exists; advertised bit 31 reads 0 out of reset and 1 in reset.
// - Opcode B9h enters deep sleep.
// - Opcode ABh leaves deep sleep.
// - Ready for commands 30 us after wake.
// - Status 05h bit 0 shows busy.
// - Erase pause completes within 40 us.
// - Host waits 128 us resume to pause.
`include "srpd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module srpd_dev #(
  parameter logic [23:0] OP_CYC   = 24'h000800,
  parameter logic [15:0] WAKE_CYC = 16'(`SRPD_WAKE_CYC)
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  // Link
  srpd_if.dev                  link,
  // Operation starts from the array side
  input  wire logic            start_erase,
  input  wire logic            start_prog,
  // Status
  output logic                 operation_busy_flag,
  output logic                 deep_sleep_state,
  output logic                 paused_erase,
  output logic                 paused_prog,
  output logic                 sleep_adv_bit
);
  import srpd_pkg::*;
  srpd_dev_state_type st_r;
  logic [23:0]        op_cnt_r;
  logic [15:0]        wake_cnt_r;
  logic [15:0]        stop_cnt_r;
  logic               was_erase_r;
  logic               stopping_r;
  logic               take;
  logic               waking;
  logic               running;
  logic               erase_pause;
  logic               prog_pause;
  logic               pause_hit;
  logic               stop_done;
  logic               op_start;
  logic               erase_resume;
  logic               prog_resume;
  logic               wake_hit;
  // While waking the device drops commands, so a host that breaks the delay sees no effect.
  assign waking = (wake_cnt_r != 16'h0000);
  assign take = link.cmd_valid && !waking &&
                ((st_r != SRPD_SLEEP) || (link.cmd_op == `SRPD_OP_WAKE));
  assign running      = (st_r == SRPD_ERASE) || (st_r == SRPD_PROG);
  assign erase_pause  = take && (st_r == SRPD_ERASE) &&
                        (link.cmd_op == `SRPD_OP_ERS_SUSP);
  assign prog_pause   = take && (st_r == SRPD_PROG) &&
                        (link.cmd_op == `SRPD_OP_PGM_SUSP);
  // A pause that arrives while a stop is already under way changes nothing.
  assign pause_hit    = !stopping_r && (erase_pause || prog_pause);
  assign stop_done    = stopping_r && (stop_cnt_r == `SRPD_SUSP_STOP_CYC);
  // A sleep command in the same cycle as a start wins, and the start is lost.
  assign op_start     = (st_r == SRPD_IDLE) && (start_erase || start_prog) &&
                        !(take && (link.cmd_op == `SRPD_OP_SLEEP));
  assign erase_resume = take && (st_r == SRPD_PAUSED) && was_erase_r &&
                        (link.cmd_op == `SRPD_OP_ERS_RESM);
  assign prog_resume  = take && (st_r == SRPD_PAUSED) && !was_erase_r &&
                        (link.cmd_op == `SRPD_OP_PGM_RESM);
  assign wake_hit     = take && (st_r == SRPD_SLEEP) && (link.cmd_op == `SRPD_OP_WAKE);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= SRPD_IDLE;
    else
    begin
      case (st_r)
        SRPD_IDLE:
        begin
          if (take && link.cmd_op == `SRPD_OP_SLEEP)
            st_r <= SRPD_SLEEP;
          else if (op_start)
            st_r <= start_erase ? SRPD_ERASE : SRPD_PROG;
        end
        SRPD_ERASE, SRPD_PROG:
        begin
          // The stop takes a fixed short time, well inside the advertised limit.
          if (stop_done)
            st_r <= SRPD_PAUSED;
          else if (!stopping_r && !pause_hit && op_cnt_r == 24'h000000)
            st_r <= SRPD_IDLE;
        end
        SRPD_PAUSED:
        begin
          if (erase_resume)
            st_r <= SRPD_ERASE;
          else if (prog_resume)
            st_r <= SRPD_PROG;
        end
        SRPD_SLEEP:
        begin
          if (wake_hit)
            st_r <= SRPD_IDLE;
        end
        default:
          st_r <= SRPD_IDLE;
      endcase
    end
  end
  // The countdown freezes during a stop, so a resume picks up where it left off.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      op_cnt_r <= 24'h000000;
    else if (op_start)
      op_cnt_r <= OP_CYC;
    else if (running && !stopping_r && !pause_hit && op_cnt_r != 24'h000000)
      op_cnt_r <= op_cnt_r - 24'h000001;
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      was_erase_r <= 1'b0;
    else if (op_start)
      was_erase_r <= start_erase;
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stopping_r <= 1'b0;
      stop_cnt_r <= 16'h0000;
    end
    else if (stopping_r)
    begin
      stop_cnt_r <= stop_cnt_r + 16'h0001;
      if (stop_done)
        stopping_r <= 1'b0;
    end
    else if (pause_hit)
    begin
      stopping_r <= 1'b1;
      stop_cnt_r <= 16'h0000;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      wake_cnt_r <= 16'h0000;
    else if (wake_hit)
      wake_cnt_r <= WAKE_CYC;
    else if (waking)
      wake_cnt_r <= wake_cnt_r - 16'h0001;
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      link.stat_valid <= 1'b0;
    else
      link.stat_valid <= take && (link.cmd_op == `SRPD_OP_RDSTAT);
  end
  // The busy bit shows the state at the edge that accepts the status command.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      link.stat_data <= 8'h00;
    else
      link.stat_data <= {7'h00, running};
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      operation_busy_flag <= 1'b0;
      deep_sleep_state    <= 1'b0;
    end
    else
    begin
      operation_busy_flag <= running;
      deep_sleep_state    <= (st_r == SRPD_SLEEP);
    end
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      paused_erase <= 1'b0;
      paused_prog  <= 1'b0;
    end
    else
    begin
      paused_erase <= (st_r == SRPD_PAUSED) && was_erase_r;
      paused_prog  <= (st_r == SRPD_PAUSED) && !was_erase_r;
    end
  end
  // The advertised flag reads 1 in reset and SRPD_SLEEP_FLAG_VAL after; the flop keeps every output registered.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sleep_adv_bit <= 1'b1;
    else
      sleep_adv_bit <= `SRPD_SLEEP_FLAG_VAL;
  end
endmodule // srpd_dev
`default_nettype wire

// file: srpd_cfg.svh
// Purpose: Shared constants for the suspend, resume and deep sleep command pair.
// Assumes: core_clk runs at 200 MHz.
// Notes:   Times are given in ns and converted to cycles here, except the stop length, given in cycles.
`ifndef SRPD_CFG_SVH
`define SRPD_CFG_SVH
`define SRPD_OP_ERS_SUSP      8'h75
`define SRPD_OP_ERS_RESM      8'h7A
`define SRPD_OP_PGM_SUSP      8'h85
`define SRPD_OP_PGM_RESM      8'h8A
`define SRPD_OP_SLEEP         8'hB9
`define SRPD_OP_WAKE          8'hAB
`define SRPD_OP_RDSTAT        8'h05
`define SRPD_OP_ERASE         8'hD8
`define SRPD_OP_PROG          8'h02
`define SRPD_BUSY_BIT         0
`define SRPD_SLEEP_FLAG_BIT   31
`define SRPD_SLEEP_FLAG_VAL   1'b0
`define SRPD_CLK_PERIOD_NS    5
`define SRPD_WAKE_CNT_FIELD   5'h1D
`define SRPD_WAKE_UNIT_NS     1000
`define SRPD_WAKE_NS          ((`SRPD_WAKE_CNT_FIELD + 1) * `SRPD_WAKE_UNIT_NS)
`define SRPD_WAKE_CYC         ((`SRPD_WAKE_NS + `SRPD_CLK_PERIOD_NS - 1) / `SRPD_CLK_PERIOD_NS)
`define SRPD_SUSP_CNT_FIELD   5'h04
`define SRPD_SUSP_UNIT_NS     8000
`define SRPD_SUSP_NS          ((`SRPD_SUSP_CNT_FIELD + 1) * `SRPD_SUSP_UNIT_NS)
`define SRPD_SUSP_CYC         (`SRPD_SUSP_NS / `SRPD_CLK_PERIOD_NS)
`define SRPD_GAP_CNT_FIELD    4'h1
`define SRPD_GAP_UNIT_NS      64000
`define SRPD_GAP_NS           ((`SRPD_GAP_CNT_FIELD + 1) * `SRPD_GAP_UNIT_NS)
`define SRPD_GAP_CYC          ((`SRPD_GAP_NS + `SRPD_CLK_PERIOD_NS - 1) / `SRPD_CLK_PERIOD_NS)
`define SRPD_SUSP_STOP_CYC    16'h0010
`endif

// file: srpd_pkg.sv
// Purpose: Types shared by both ends of the command link.
// Assumes: Nothing beyond the constants header.
// Notes:   Opcodes live in the header as macros.
package srpd_pkg;
  typedef logic [7:0] srpd_op_type;
  typedef enum logic [4:0] {
    SRPD_IDLE   = 5'h01,
    SRPD_ERASE  = 5'h02,
    SRPD_PROG   = 5'h04,
    SRPD_PAUSED = 5'h08,
    SRPD_SLEEP  = 5'h10
  } srpd_dev_state_type;
  typedef enum logic [3:0] {
    SRPD_H_IDLE = 4'h1,
    SRPD_H_SEND = 4'h2,
    SRPD_H_WAIT = 4'h4,
    SRPD_H_HOLD = 4'h8
  } srpd_host_state_type;
endpackage

// file: srpd_if.sv
// Purpose: Command link between the host end and the flash end.
// Assumes: One opcode per valid cycle, status answered on the next cycle.
// Notes:   A byte-wide model of the serial frame; no tristate pins needed.
`timescale 1ns/1ps
`default_nettype none
interface srpd_if;
  logic       cmd_valid;
  logic [7:0] cmd_op;
  logic       stat_valid;
  logic [7:0] stat_data;
  modport host (output cmd_valid, output cmd_op, input stat_valid, input stat_data);
  modport dev  (input cmd_valid, input cmd_op, output stat_valid, output stat_data);
endinterface
`default_nettype wire

// file: srpd_host.sv
// Purpose: Host end that issues suspend, resume, sleep, wake and status commands.
// Assumes: User requests are held until taken; one is taken only while req_ready is high.
// Notes:   The host enforces the wake delay and the resume to pause gap itself.
`include "srpd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module srpd_host #(
  parameter logic [15:0] WAKE_CYC = 16'(`SRPD_WAKE_CYC),
  parameter logic [15:0] GAP_CYC  = 16'(`SRPD_GAP_CYC)
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // User request
  input  wire logic                req_valid,
  input  wire srpd_pkg::srpd_op_type req_op,
  output logic                     req_ready,
  // Status answer
  output logic                     stat_done,
  output logic                     stat_busy,
  // Link
  srpd_if.host                     link
);
  import srpd_pkg::*;
  srpd_host_state_type st_r;
  logic [15:0]         wait_r;
  logic [15:0]         gap_r;
  logic                is_pause;
  assign is_pause = (req_op == `SRPD_OP_ERS_SUSP) || (req_op == `SRPD_OP_PGM_SUSP);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r          <= SRPD_H_IDLE;
      link.cmd_valid <= 1'b0;
      link.cmd_op    <= 8'h00;
      req_ready     <= 1'b0;
      wait_r        <= 16'h0000;
    end
    else
    begin
      link.cmd_valid <= 1'b0;
      case (st_r)
        SRPD_H_IDLE:
        begin
          req_ready <= 1'b1;
          // A pause inside the gap is refused: req_ready drops for a cycle and nothing is stored.
          if (req_valid && req_ready && !(is_pause && gap_r != 16'h0000))
          begin
            link.cmd_valid <= 1'b1;
            link.cmd_op    <= req_op;
            req_ready     <= 1'b0;
            st_r          <= (req_op == `SRPD_OP_WAKE) ? SRPD_H_HOLD :
                             (req_op == `SRPD_OP_RDSTAT) ? SRPD_H_WAIT : SRPD_H_SEND;
            wait_r        <= WAKE_CYC;
          end
          else if (req_valid && req_ready)
            req_ready <= 1'b0;
        end
        SRPD_H_SEND:
          st_r <= SRPD_H_IDLE;
        SRPD_H_WAIT:
          if (link.stat_valid)
            st_r <= SRPD_H_IDLE;
        SRPD_H_HOLD:
        begin
          wait_r <= wait_r - 16'h0001;
          if (wait_r == 16'h0001)
            st_r <= SRPD_H_IDLE;
        end
        default:
          st_r <= SRPD_H_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      gap_r <= 16'h0000;
    else if (link.cmd_valid &&
             (link.cmd_op == `SRPD_OP_ERS_RESM || link.cmd_op == `SRPD_OP_PGM_RESM))
      gap_r <= GAP_CYC;
    else if (gap_r != 16'h0000)
      gap_r <= gap_r - 16'h0001;
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_done <= 1'b0;
      stat_busy <= 1'b0;
    end
    else
    begin
      stat_done <= link.stat_valid;
      if (link.stat_valid)
        stat_busy <= link.stat_data[`SRPD_BUSY_BIT];
    end
  end
endmodule // srpd_host
`default_nettype wire

// file: srpd_checker.sv
// Purpose: Link checks between the host end and the flash end.
// Assumes: Parameters match those of the two ends.
// Notes:   Sleep is tracked from link opcodes only.
`timescale 1ns/1ps
`default_nettype none
module srpd_checker #(
  parameter logic [15:0] WAKE_CYC = 16'h0020,
  parameter logic [15:0] GAP_CYC  = 16'h0030
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Link
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic       stat_valid,
  input wire logic [7:0] stat_data
);
  logic [15:0] wake_r;
  logic [15:0] gap_r;
  logic        slp_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // One cycle of margin, so a host that is exact is not flagged.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_r <= 16'h0000;
      gap_r  <= 16'h0000;
      slp_r  <= 1'b0;
    end
    else
    begin
      wake_r <= (cmd_valid && cmd_op == 8'hAB) ? WAKE_CYC - 16'h0001 :
                (wake_r != 16'h0000) ? wake_r - 16'h0001 : wake_r;
      gap_r  <= (cmd_valid && (cmd_op == 8'h7A || cmd_op == 8'h8A)) ? GAP_CYC - 16'h0001 :
                (gap_r != 16'h0000) ? gap_r - 16'h0001 : gap_r;
      slp_r  <= (cmd_valid && cmd_op == 8'hB9) ? 1'b1 :
                (cmd_valid && cmd_op == 8'hAB) ? 1'b0 : slp_r;
    end
  end
  stat_only_a: assert property (stat_valid |->
    $past(cmd_valid) && $past(cmd_op) == 8'h05)
    else $error("status answer without status command");
  stat_answer_a: assert property (cmd_valid && cmd_op == 8'h05 && !slp_r |=>
    stat_valid)
    else $error("status command not answered");
  stat_rsvd_a: assert property (stat_valid |-> stat_data[7:1] == 7'h00)
    else $error("status upper bits not zero");
  stat_pulse_a: assert property (stat_valid |=> !stat_valid)
    else $error("status answer longer than one cycle");
  cmd_space_a: assert property (cmd_valid |=> !cmd_valid [*2])
    else $error("commands too close");
  wake_gap_a: assert property (cmd_valid |-> wake_r == 16'h0000)
    else $error("command inside wake delay");
  resume_gap_a: assert property (cmd_valid && (cmd_op == 8'h75 || cmd_op == 8'h85) |->
    gap_r == 16'h0000)
    else $error("pause inside resume gap");
  sleep_mute_a: assert property (stat_valid |-> !slp_r)
    else $error("answer while sleeping");
endmodule // srpd_checker
`default_nettype wire

// file: srpd_tb.sv
// Purpose: Self-checking bench for both ends of the command link.
// Assumes: Short op, wake and gap counts keep the run brief.
// Notes:   Status is never polled in sleep, as the host would hang.
`timescale 1ns/1ps
`default_nettype none
`define SRPD_CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module srpd_tb;
  import srpd_pkg::*;
  localparam logic [23:0] OP_CYC   = 24'h000040;
  localparam logic [15:0] WAKE_CYC = 16'h0020;
  localparam logic [15:0] GAP_CYC  = 16'h0030;
  logic        core_clk, rst_b, start_erase, start_prog, req_valid, req_ready;
  logic        stat_done, stat_busy, operation_busy_flag, deep_sleep_state;
  logic        paused_erase, paused_prog, sleep_adv_bit;
  srpd_op_type req_op;
  int          failures, comparisons, cyc, n;
  srpd_if link ();
  srpd_dev #(.OP_CYC(OP_CYC), .WAKE_CYC(WAKE_CYC)) u_srpd_dev (.core_clk(core_clk),
    .rst_b(rst_b), .link(link), .start_erase(start_erase), .start_prog(start_prog),
    .operation_busy_flag(operation_busy_flag), .deep_sleep_state(deep_sleep_state),
    .paused_erase(paused_erase), .paused_prog(paused_prog), .sleep_adv_bit(sleep_adv_bit));
  srpd_host #(.WAKE_CYC(WAKE_CYC), .GAP_CYC(GAP_CYC)) u_srpd_host (.core_clk(core_clk),
    .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op), .req_ready(req_ready),
    .stat_done(stat_done), .stat_busy(stat_busy), .link(link));
  srpd_checker #(.WAKE_CYC(WAKE_CYC), .GAP_CYC(GAP_CYC)) u_srpd_checker (.core_clk(core_clk),
    .rst_b(rst_b), .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
    .stat_valid(link.stat_valid), .stat_data(link.stat_data));
  task automatic end_sim();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Holds the request until the host puts it on the link. A pause held back by the
  // resume gap sees ready drop for a cycle, so the request stays up and is offered again.
  task automatic send(input srpd_op_type op);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op    <= op;
    do
    begin
      do @(posedge core_clk); while (req_ready !== 1'b1);
      @(posedge core_clk);
    end
    while (link.cmd_valid !== 1'b1);
    req_valid <= 1'b0;
  endtask
  task automatic poll(input logic exp);
    send(8'h05);
    do @(posedge core_clk); while (stat_done !== 1'b1);
    #1;
    `SRPD_CHK("stat_busy", exp, stat_busy)
  endtask
  task automatic pulse(input logic erase);
    @(posedge core_clk);
    start_erase <= erase;
    start_prog  <= !erase;
    @(posedge core_clk);
    start_erase <= 1'b0;
    start_prog  <= 1'b0;
  endtask
  task automatic settle(input int cycles);
    repeat (cycles) @(posedge core_clk);
    #1;
  endtask
  task automatic t_erase();
    pulse(1'b1);
    poll(1'b1);
    send(8'h75);
    settle(22);
    `SRPD_CHK("paused_erase", 1'b1, paused_erase)
    poll(1'b0);
    send(8'h7A);
    settle(3);
    `SRPD_CHK("resumed_busy", 1'b1, operation_busy_flag)
    // Pause right after resume: the host must hold it back.
    send(8'h75);
    settle(22);
    `SRPD_CHK("paused_again", 1'b1, paused_erase)
    send(8'h7A);
    settle(80);
    poll(1'b0);
  endtask
  task automatic t_prog();
    pulse(1'b0);
    send(8'h75);
    settle(22);
    `SRPD_CHK("wrong_pause", 1'b0, paused_erase)
    `SRPD_CHK("wrong_pause_prog", 1'b0, paused_prog)
    send(8'h85);
    settle(22);
    `SRPD_CHK("paused_prog", 1'b1, paused_prog)
    send(8'h8A);
    settle(3);
    `SRPD_CHK("prog_resumed", 1'b0, paused_prog)
    settle(80);
    poll(1'b0);
  endtask
  task automatic t_sleep();
    send(8'hB9);
    settle(3);
    `SRPD_CHK("asleep", 1'b1, deep_sleep_state)
    send(8'h7A);
    send(8'hB9);
    settle(3);
    `SRPD_CHK("still_asleep", 1'b1, deep_sleep_state)
    send(8'hAB);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 400);
    `SRPD_CHK("awake", 1'b0, deep_sleep_state)
    `SRPD_CHK("wake_wait", 1'b1, n >= int'(WAKE_CYC))
    poll(1'b0);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // No test should need more than a couple of thousand cycles.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      end_sim();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    start_erase = 1'b0;
    start_prog = 1'b0;
    req_valid = 1'b0;
    req_op = 8'h00;
    repeat (3) @(posedge core_clk);
    `SRPD_CHK("adv_in_reset", 1'b1, sleep_adv_bit)
    rst_b <= 1'b1;
    settle(2);
    `SRPD_CHK("adv_bit", 1'b0, sleep_adv_bit)
    t_erase();
    t_prog();
    t_sleep();
    end_sim();
  end
endmodule // srpd_tb
`default_nettype wire
